// *** hw/dsps_ctrl.sv ***
// dsps_ctrl: controller that runs a dual-slope analog processor through its phases
// assumes phase pins a/b go straight to the device and comparator comes back asynchronously
//
// Behaviour
// [RL1] phase pins a/b encode auto-zero, integrate, deintegrate, integrator zero
// [RL2] device closes switches per phase; controller only selects the phase
// [RL3] device auto-zeroes inputs and stores offset during auto-zero
// [RL4] device integrates differential input during integration
// [RL5] polarity is sampled from comparator at end of integration
// [RL6] device applies reference opposite to input polarity in deintegration
// [RL7] every deintegration is followed by integrator output zero
// [RL8] integrator zero is always used, so resolution above 14 bits is fine
// [RL9] integrator zero lasts until comparator high or about 2 ms
// [RL10] cycle order is auto-zero, integrate, deintegrate, integrator zero
// [RL11] comparator high means positive input during integration
// [RL12] comparator falling during deintegration marks conversion complete
// [RL13] comparator is ignored during auto-zero
// [RL14] phase pins are held steady for the whole phase
// [RL15] integration is a fixed count; deintegration count is the magnitude
`timescale 1ns/1ps
module dsps_ctrl
   import dsps_pkg::*;
#(
   parameter int AUTO_ZERO_CYCLES = AUTO_ZERO_CYCLES_DEF,
   parameter int INTEGRATE_CYCLES = INTEGRATE_CYCLES_DEF,
   parameter int IZ_CYCLES = INT_ZERO_CYCLES,
   parameter logic [COUNT_W-1:0] REFERENCE_RAMP_PHASE_LIMIT = 32'h0000ffff
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // user side
   input wire logic start_i,
   output logic busy_o,
   output logic done_o,
   output dsps_result_type result_o,
   // device pins
   input wire logic comp_i,
   output logic phase_a_o,
   output logic phase_b_o
);
   // =====================================================
   // state and counters
   dsps_state_type state, next_state;
   logic [COUNT_W-1:0] count, next_count;
   logic comp_s;
   logic comp_d;
   logic [1:0] phase_code;
   logic az_end, int_end, reference_ramp_phase_fall, reference_ramp_phase_ovr, iz_end, iz_timeout, iz_rise;

   dsps_sync u_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .async_i(comp_i),
      .sync_o(comp_s)
   );

   // previous synchronised comparator for edge detection
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         comp_d <= 1'b0;
      end else begin
         comp_d <= comp_s;
      end
   end

   // =====================================================
   // phase end decode
   assign az_end = (state == ST_AZ) && (count == COUNT_W'(AUTO_ZERO_CYCLES - 1));
   // [RL15] fixed integration count
   assign int_end = (state == ST_INT) && (count == COUNT_W'(INTEGRATE_CYCLES - 1));
   // [RL12] falling comparator ends deintegration
   assign reference_ramp_phase_fall = (state == ST_REFERENCE_RAMP_PHASE) && comp_d && !comp_s;
   assign reference_ramp_phase_ovr = (state == ST_REFERENCE_RAMP_PHASE) && (count == REFERENCE_RAMP_PHASE_LIMIT);
   // [RL9] comparator returning high or fixed time ends zero phase
   // a level still high after an overrange ramp must not end the phase at once,
   // so only a fresh rise of the synchronised comparator counts as its return
   assign iz_rise = comp_s && !comp_d;
   assign iz_timeout = (count == COUNT_W'(IZ_CYCLES - 1));
   assign iz_end = (state == ST_IZ) && (iz_rise || iz_timeout);

   // [RL10] next state in documented order
   always_comb begin
      next_state = state;
      next_count = count + 1'b1;
      unique case (state)
         ST_IDLE: begin
            next_count = '0;
            if (start_i) begin
               next_state = ST_AZ;
            end
         end
         ST_AZ: begin
            // [RL13] comparator not looked at here
            if (az_end) begin
               next_state = ST_INT;
               next_count = '0;
            end
         end
         ST_INT: begin
            if (int_end) begin
               next_state = ST_REFERENCE_RAMP_PHASE;
               next_count = '0;
            end
         end
         ST_REFERENCE_RAMP_PHASE: begin
            // [RL7] always followed by integrator zero
            // [RL8] zero phase never skipped
            if (reference_ramp_phase_fall || reference_ramp_phase_ovr) begin
               next_state = ST_IZ;
               next_count = '0;
            end
         end
         ST_IZ: begin
            if (iz_end) begin
               next_state = ST_IDLE;
               next_count = '0;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= ST_IDLE;
         count <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   // =====================================================
   // [RL1] phase code per state; idle parks in auto-zero
   assign phase_code = (state == ST_INT) ? PHASE_INTEGRATE :
                       (state == ST_REFERENCE_RAMP_PHASE) ? PHASE_REFERENCE_RAMP_PHASE :
                       (state == ST_IZ) ? PHASE_INT_ZERO : PHASE_AUTO_ZERO;

   // [RL14] pins registered, change only on state change
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         phase_a_o <= PHASE_AUTO_ZERO[1];
         phase_b_o <= PHASE_AUTO_ZERO[0];
      end else begin
         phase_a_o <= phase_code[1];
         phase_b_o <= phase_code[0];
      end
   end

   // =====================================================
   // result capture
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         result_o <= '0;
         done_o <= 1'b0;
      end else begin
         done_o <= iz_end;
         // [RL5] polarity from comparator at end of integration
         if (int_end) begin
            result_o.negative <= !comp_s;
         end
         // [RL15] deintegration count is magnitude
         if (reference_ramp_phase_fall || reference_ramp_phase_ovr) begin
            result_o.magnitude <= count;
            result_o.overrange <= reference_ramp_phase_ovr && !reference_ramp_phase_fall;
         end
      end
   end

   assign busy_o = (state != ST_IDLE);

   // =====================================================
   // checks
   // [RL1] integrate code while integrating
   phase_code_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL1
      $past(state) == ST_INT |-> {phase_a_o, phase_b_o} == PHASE_INTEGRATE)
      else $error("integrate code missing");
   // [RL10] deintegration entered only from integration
   phase_order_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL10
      state == ST_REFERENCE_RAMP_PHASE && $past(state) != ST_REFERENCE_RAMP_PHASE |-> $past(state) == ST_INT)
      else $error("deintegration entered out of order");
   // [RL7] deintegration leaves only to integrator zero
   reference_ramp_phase_follow_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL7
      state == ST_REFERENCE_RAMP_PHASE ##1 state != ST_REFERENCE_RAMP_PHASE |-> state == ST_IZ)
      else $error("deintegration not followed by zero phase");
   // [RL15] integration length fixed
   int_length_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL15
      int_end |-> $past(state, 1) == ST_INT && count == COUNT_W'(INTEGRATE_CYCLES - 1))
      else $error("integration length wrong");
   // [RL9] zero phase bounded by timeout
   iz_bound_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL9
      state == ST_IZ |-> count < COUNT_W'(IZ_CYCLES))
      else $error("zero phase too long");
   // [RL12] falling comparator ends deintegration next cycle
   reference_ramp_phase_stop_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL12
      reference_ramp_phase_fall |=> state == ST_IZ && result_o.magnitude == $past(count))
      else $error("deintegration not ended on fall");
   // [RL5] polarity captured at integration end
   polarity_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL5
      int_end |=> result_o.negative == !$past(comp_s))
      else $error("polarity not captured");
   // [RL14] pins steady within a phase
   pins_steady_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL14
      $stable(state) ##1 1'b1 |-> $stable({phase_a_o, phase_b_o}))
      else $error("phase pins moved mid phase");
endmodule

// *** hw/dsps_pkg.sv ***
// dsps_pkg: shared constants and types for the dual-slope phase sequencer controller
// assumes a 200 MHz system clock
package dsps_pkg;
   // =====================================================
   // phase select codes {a, b}
   localparam logic [1:0] PHASE_AUTO_ZERO = 2'h1;
   localparam logic [1:0] PHASE_INTEGRATE = 2'h2;
   localparam logic [1:0] PHASE_REFERENCE_RAMP_PHASE = 2'h3;
   localparam logic [1:0] PHASE_INT_ZERO = 2'h0;
   // =====================================================
   // timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int INT_ZERO_TIME_US = 2000;
   localparam int INT_ZERO_CYCLES = (INT_ZERO_TIME_US * 1000000) / CLK_PERIOD_PS;
   localparam int AUTO_ZERO_CYCLES_DEF = 1000;
   localparam int INTEGRATE_CYCLES_DEF = 2000;
   localparam int COUNT_W = 32;
   localparam int SYNC_STAGES = 2;
   // =====================================================
   // result carrier
   typedef struct packed {
      logic negative;
      logic overrange;
      logic [COUNT_W-1:0] magnitude;
   } dsps_result_type;
   // =====================================================
   // sequencer states
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_AZ = 5'h02,
      ST_INT = 5'h04,
      ST_REFERENCE_RAMP_PHASE = 5'h08,
      ST_IZ = 5'h10
   } dsps_state_type;
endpackage

// *** hw/dsps_sync.sv ***
// dsps_sync: two flip-flop synchroniser for an asynchronous level
// assumes input is a pin from outside the clock domain
`timescale 1ns/1ps
module dsps_sync (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // level
   input wire logic async_i,
   output logic sync_o
);
   // =====================================================
   // synchroniser
   logic meta;
   // first stage read only by second
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule

// *** dv/dsps_dev_model.sv ***
// dsps_dev_model: behavioural analog processor seen at its phase and comparator pins
// assumes the bench supplies the input level and the integrator-zero settle time
`timescale 1ns/1ps
module dsps_dev_model
   import dsps_pkg::*;
(
   // clock and pins
   input wire logic clk_i,
   input wire logic phase_a_i,
   input wire logic phase_b_i,
   output logic comp_o,
   // analog stand-ins
   input wire integer vin_i,
   input wire integer iz_settle_i
);
   int integ = 0;
   int iz_n = 0;
   logic neg = 1'b0;
   wire logic [1:0] ph = {phase_a_i, phase_b_i};
   initial comp_o = 1'b0;
   // =====================================
   // integrator and comparator per phase
   always @(posedge clk_i) begin
      iz_n <= (ph == PHASE_INT_ZERO) ? iz_n + 1 : 0;
      case (ph)
         PHASE_AUTO_ZERO: begin
            integ <= 0;
            comp_o <= ~comp_o;
         end
         PHASE_INTEGRATE: begin
            integ <= integ + vin_i;
            neg <= (vin_i < 0);
            comp_o <= (vin_i > 0);
         end
         PHASE_REFERENCE_RAMP_PHASE: begin
            integ <= neg ? integ + 1 : integ - 1;
            comp_o <= neg ? (integ + 1 < 0) : (integ - 1 > 0);
         end
         // integrator held at zero; comparator goes high once settled
         default: begin
            integ <= 0;
            comp_o <= (iz_n >= iz_settle_i);
         end
      endcase
   end
endmodule

// *** dv/dsps_ctrl_bench.sv ***
// dsps_ctrl_bench: random and corner conversions against the device model
// assumes short phase counts set through the controller parameters
`timescale 1ns/1ps
module dsps_ctrl_bench;
   import dsps_pkg::*;
   localparam int INTC = 16;
   localparam int IZC = 50;
   localparam logic [COUNT_W-1:0] LIM = 32'h00000100;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("[ERR] %0t value mismatch", $time); end end
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic start_i = 1'b0;
   logic busy_o, done_o, comp_i, phase_a_o, phase_b_o;
   dsps_result_type result_o;
   int vin = 1;
   int settle = 0;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   int ph_n = 0;
   int dones = 0;
   int corner[4] = '{1, -1, -20, 15};
   logic [1:0] prev_ph = PHASE_AUTO_ZERO;
   logic [31:0] lfsr = 32'hfcc7806b;
   wire logic [1:0] ph = {phase_a_o, phase_b_o};
   dsps_ctrl #(.AUTO_ZERO_CYCLES(8), .INTEGRATE_CYCLES(INTC), .IZ_CYCLES(IZC),
      .REFERENCE_RAMP_PHASE_LIMIT(LIM)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i),
      .busy_o(busy_o), .done_o(done_o), .result_o(result_o), .comp_i(comp_i),
      .phase_a_o(phase_a_o), .phase_b_o(phase_b_o));
   dsps_dev_model model (.clk_i(clk_i), .phase_a_i(phase_a_o), .phase_b_i(phase_b_o),
      .comp_o(comp_i), .vin_i(vin), .iz_settle_i(settle));
   // =====================================
   // expectation helpers
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] ramp(input int v);
      return (v < 0 ? -v : v) * INTC;
   endfunction
   function automatic logic [1:0] exp_next(input logic [1:0] p);
      case (p)
         PHASE_AUTO_ZERO: return PHASE_INTEGRATE;
         PHASE_INTEGRATE: return PHASE_REFERENCE_RAMP_PHASE;
         PHASE_REFERENCE_RAMP_PHASE: return PHASE_INT_ZERO;
         default: return PHASE_AUTO_ZERO;
      endcase
   endfunction
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // one conversion with an extra start while busy
   task automatic run_one(input int v, input int s);
      int w;
      int d0;
      vin <= v;
      settle <= s;
      d0 = dones;
      start_i <= 1'b1;
      @(posedge clk_i);
      start_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      start_i <= 1'b1;
      `CHK(busy_o, 1'b1)
      @(posedge clk_i);
      start_i <= 1'b0;
      w = 0;
      while (done_o !== 1'b1 && w < 2000) begin
         @(posedge clk_i);
         w++;
      end
      `CHK(result_o.negative, 1'(v < 0))
      `CHK(result_o.overrange, 1'(ramp(v) > LIM))
      if (ramp(v) <= LIM) `CHK(result_o.magnitude + 2 - ramp(v) <= 10, 1'b1)
      repeat (3) @(posedge clk_i);
      `CHK(dones - d0, 1)
      `CHK(busy_o, 1'b0)
   endtask
   // =====================================
   // clock, pin order monitor and timeout
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         error_cnt++;
         test_done();
      end
      if (done_o === 1'b1) dones <= dones + 1;
      if (rst_b_i && ph !== prev_ph) begin
         `CHK(ph, exp_next(prev_ph))
         if (prev_ph === PHASE_INTEGRATE) `CHK(ph_n, INTC)
         if (prev_ph === PHASE_INT_ZERO) `CHK(ph_n <= IZC + 4, 1'b1)
         if (prev_ph === PHASE_INT_ZERO) `CHK(ph_n >= (settle < IZC ? settle : IZC), 1'b1)
         ph_n <= 1;
      end else begin
         ph_n <= ph_n + 1;
      end
      prev_ph <= ph;
   end
   // =====================================
   // main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      `CHK({ph, busy_o, done_o}, {PHASE_AUTO_ZERO, 2'b00})
      `CHK(result_o, '0)
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      for (int i = 0; i < 14; i++) begin
         lfsr = lfsr_next(lfsr);
         run_one(i < 4 ? corner[i] : (lfsr[4] ? -1 : 1) * (int'(lfsr[3:0]) % 15 + 1),
            int'(lfsr[13:8]));
      end
      test_done();
   end
endmodule
